// ---- hdl/pin_config.sv ----
// Three configurable pins with their registers behind a serial configuration port.
`timescale 1ns/1ns
// Notes on behaviour
// - Pin 0 mode picks software bit, clock loss, clock detect or power reset.
// - Pin 1 mode picks power reset, software bit, PLL lock or lane loss.
// - Pin 2 mode picks software bit, high, serial, parallel or lane clock.
// - Pull field: 00 none, 01 pull-down, 10 pull-up, 11 reserved; resets 01.
// - Bit 1 enables the pin input buffer; it resets to zero.
// - Bit 0 enables the output driver; pins 0 and 1 reset driving.
// - Pin 2 driver enable resets to zero, leaving the pin held low by its pull-down.
// - Writing the soft reset bit restores power-up state, then the bit clears.
// - Software mode drives the pin from a per-pin output register, reset zero.
module pin_config #(
    parameter logic [6:0] bus_address = pin_config_pkg::bus_address_default
) (
    input  wire logic                                     sys_clk,
    input  wire logic                                     rst,
    input  wire logic                                     scl_in,
    input  wire logic                                     sda_in,
    output logic                                          sda_out,
    output logic                                          sda_oe_n,
    input  wire pin_config_pkg::status_type               status_in,
    input  wire logic                                     serial_clock,
    input  wire logic                                     parallel_clock,
    input  wire logic                                     input_lane_clock,
    input  wire logic [pin_config_pkg::pin_count-1:0]     pin_in,
    output pin_config_pkg::pin_pad_type [pin_config_pkg::pin_count-1:0] pads
);

    pin_config_pkg::pin_cfg_type [pin_config_pkg::pin_count-1:0] cfg;
    pin_config_pkg::status_type  status_meta;
    pin_config_pkg::status_type  status_sync;
    pin_config_pkg::bus_state_type state;
    logic [pin_config_pkg::pin_count-1:0] software_output_bit;
    logic [pin_config_pkg::pin_count-1:0] pin_meta;
    logic [pin_config_pkg::pin_count-1:0] pin_sync;
    logic [pin_config_pkg::pin_count-1:0] pin_q;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic       software_reset_bit;
    logic       reg_rst;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic [3:0] cnt;
    logic       wr_strobe;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       clk_sel;
    logic       clk_pick;
    logic [2:0] pad_data;
    logic [3:0] lane_sel;
    logic [7:0] read_now;
    logic [7:0] read_next;

    // Soft reset clears everything except the serial engine, so the write that
    // raised it still completes its acknowledge on the wire.
    assign reg_rst = rst | software_reset_bit;

    // Pin and status inputs come from other domains and pass two flops first.
    always_ff @(posedge sys_clk) begin
        scl_s       <= {scl_s[1:0], scl_in};
        sda_s       <= {sda_s[1:0], sda_in};
        pin_meta    <= pin_in;
        pin_sync    <= pin_meta;
        status_meta <= status_in;
        status_sync <= status_meta;
    end

    assign scl_rise  = scl_s[1] & ~scl_s[2];
    assign scl_fall  = ~scl_s[1] & scl_s[2];
    assign bus_start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
    assign bus_stop  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
    assign sda_out   = 1'b0;

    function automatic logic [7:0] reg_read(input logic [7:0] addr);
        logic [7:0] value;
        value = 8'h00;
        case (addr)
            pin_config_pkg::reset_offset:       value = {7'h00, software_reset_bit};
            pin_config_pkg::pin0_config_offset: value = cfg[0];
            pin_config_pkg::pin1_config_offset: value = cfg[1];
            pin_config_pkg::pin2_config_offset: value = cfg[2];
            pin_config_pkg::pin_input_offset:   value = {5'h00, pin_q};
            pin_config_pkg::pin_output_offset:  value = {5'h00, software_output_bit};
            default:                            value = 8'h00;
        endcase
        return value;
    endfunction : reg_read

    // Read data for the current and the following pointer, ready at each load.
    always_comb begin
        read_now  = reg_read(ptr);
        read_next = reg_read(ptr + 8'h01);
    end

    // Serial configuration slave: byte pointer then data, pointer auto-increments.
    always_ff @(posedge sys_clk) begin
        wr_strobe <= 1'b0;
        if (rst) begin
            state    <= pin_config_pkg::st_idle;
            sda_oe_n <= 1'b1;
            shift    <= 8'h00;
            ptr      <= 8'h00;
            cnt      <= 4'h0;
            wr_addr  <= 8'h00;
            wr_data  <= 8'h00;
        end else if (bus_start) begin
            state    <= pin_config_pkg::st_addr;
            sda_oe_n <= 1'b1;
            cnt      <= 4'h0;
        end else if (bus_stop) begin
            state    <= pin_config_pkg::st_idle;
            sda_oe_n <= 1'b1;
        end else begin
            case (state)
                pin_config_pkg::st_addr, pin_config_pkg::st_ptr, pin_config_pkg::st_wdata: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_s[1]};
                        cnt   <= cnt + 4'h1;
                    end else if (scl_fall && cnt == pin_config_pkg::bits_per_byte) begin
                        sda_oe_n <= 1'b0;
                        if (state == pin_config_pkg::st_addr) begin
                            if (shift[7:1] == bus_address) begin
                                state <= pin_config_pkg::st_addr_ack;
                            end else begin
                                state    <= pin_config_pkg::st_idle;
                                sda_oe_n <= 1'b1;
                            end
                        end else if (state == pin_config_pkg::st_ptr) begin
                            ptr   <= shift;
                            state <= pin_config_pkg::st_ptr_ack;
                        end else begin
                            wr_strobe <= 1'b1;
                            wr_addr   <= ptr;
                            wr_data   <= shift;
                            state     <= pin_config_pkg::st_data_ack;
                        end
                    end
                end
                pin_config_pkg::st_addr_ack: begin
                    if (scl_fall) begin
                        cnt <= 4'h0;
                        if (shift[0]) begin
                            shift    <= read_now;
                            sda_oe_n <= read_now[7];
                            state    <= pin_config_pkg::st_rdata;
                        end else begin
                            sda_oe_n <= 1'b1;
                            state    <= pin_config_pkg::st_ptr;
                        end
                    end
                end
                pin_config_pkg::st_ptr_ack, pin_config_pkg::st_data_ack: begin
                    if (scl_fall) begin
                        cnt      <= 4'h0;
                        sda_oe_n <= 1'b1;
                        state    <= pin_config_pkg::st_wdata;
                        if (state == pin_config_pkg::st_data_ack) begin
                            ptr <= ptr + 8'h01;
                        end
                    end
                end
                pin_config_pkg::st_rdata: begin
                    if (scl_rise) begin
                        cnt <= cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt == pin_config_pkg::bits_per_byte) begin
                            sda_oe_n <= 1'b1;
                            state    <= pin_config_pkg::st_rack;
                        end else begin
                            sda_oe_n <= shift[6];
                            shift    <= {shift[6:0], 1'b0};
                        end
                    end
                end
                pin_config_pkg::st_rack: begin
                    if (scl_rise && sda_s[1]) begin
                        state <= pin_config_pkg::st_idle;
                    end else if (scl_fall) begin
                        cnt      <= 4'h0;
                        ptr      <= ptr + 8'h01;
                        shift    <= read_next;
                        sda_oe_n <= read_next[7];
                        state    <= pin_config_pkg::st_rdata;
                    end
                end
                default: begin
                    state    <= pin_config_pkg::st_idle;
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Soft reset bit holds for one cycle, long enough to clear all register state.
    always_ff @(posedge sys_clk) begin
        if (rst || software_reset_bit) begin
            software_reset_bit <= 1'b0;
        end else if (wr_strobe && wr_addr == pin_config_pkg::reset_offset) begin
            software_reset_bit <= wr_data[pin_config_pkg::software_reset_pos];
        end
    end

    // Configuration and software output registers keep reserved codes as written.
    always_ff @(posedge sys_clk) begin
        if (reg_rst) begin
            cfg[0] <= pin_config_pkg::pin0_config_reset;
            cfg[1] <= pin_config_pkg::pin1_config_reset;
            cfg[2] <= pin_config_pkg::pin2_config_reset;
            software_output_bit <= pin_config_pkg::software_output_reset;
        end else if (wr_strobe) begin
            case (wr_addr)
                pin_config_pkg::pin0_config_offset: cfg[0] <= wr_data;
                pin_config_pkg::pin1_config_offset: cfg[1] <= wr_data;
                pin_config_pkg::pin2_config_offset: cfg[2] <= wr_data;
                pin_config_pkg::pin_output_offset:  software_output_bit <= wr_data[2:0];
                default: ;
            endcase
        end
    end

    // A pin whose input buffer is off reads as zero.
    always_ff @(posedge sys_clk) begin
        if (reg_rst) begin
            pin_q <= 3'h0;
        end else begin
            for (int i = 0; i < pin_config_pkg::pin_count; i++) begin
                pin_q[i] <= pin_sync[i] & cfg[i].input_on;
            end
        end
    end

    // Lane codes start at four, so the lane number is the code minus that base.
    assign lane_sel = cfg[1].mode - pin_config_pkg::pin1_lane_first;

    // Registered function selection; reserved codes give a low level.
    always_ff @(posedge sys_clk) begin
        if (reg_rst) begin
            pad_data <= 3'h0;
        end else begin
            case (cfg[0].mode)
                pin_config_pkg::pin0_software:    pad_data[0] <= software_output_bit[0];
                pin_config_pkg::pin0_clock_loss:  pad_data[0] <= status_sync.input_clock_loss;
                pin_config_pkg::pin0_clock_found: pad_data[0] <= status_sync.input_clock_found;
                pin_config_pkg::pin0_power_reset: pad_data[0] <= status_sync.power_reset;
                default:                          pad_data[0] <= 1'b0;
            endcase
            if (cfg[1].mode >= pin_config_pkg::pin1_lane_first
                    && cfg[1].mode <= pin_config_pkg::pin1_lane_last) begin
                pad_data[1] <= status_sync.lane_data_loss[lane_sel[2:0]];
            end else begin
                case (cfg[1].mode)
                    pin_config_pkg::pin1_power_reset: pad_data[1] <= status_sync.power_reset;
                    pin_config_pkg::pin1_software:    pad_data[1] <= software_output_bit[1];
                    pin_config_pkg::pin1_pll_lock:    pad_data[1] <= status_sync.pll_lock;
                    default:                          pad_data[1] <= 1'b0;
                endcase
            end
            case (cfg[2].mode)
                pin_config_pkg::pin2_software:    pad_data[2] <= software_output_bit[2];
                pin_config_pkg::pin2_always_high: pad_data[2] <= 1'b1;
                default:                          pad_data[2] <= 1'b0;
            endcase
        end
    end

    // Clocks cannot go through a flop at this rate, so pin 2 picks them directly;
    // the pin then carries a combinational path from the clock inputs.
    assign clk_sel = cfg[2].mode == pin_config_pkg::pin2_serial_clk
                  || cfg[2].mode == pin_config_pkg::pin2_parallel_clk
                  || cfg[2].mode == pin_config_pkg::pin2_lane_clk;
    always_comb begin
        case (cfg[2].mode)
            pin_config_pkg::pin2_serial_clk:   clk_pick = serial_clock;
            pin_config_pkg::pin2_parallel_clk: clk_pick = parallel_clock;
            pin_config_pkg::pin2_lane_clk:     clk_pick = input_lane_clock;
            default:                           clk_pick = 1'b0;
        endcase
    end

    // Pin 2 bypasses its data flop in clock modes; every other source is registered.
    always_comb begin
        for (int i = 0; i < pin_config_pkg::pin_count; i++) begin
            pads[i].oe_n         = ~cfg[i].driver_on;
            pads[i].pull_up_on   = cfg[i].pull == pin_config_pkg::pull_up;
            pads[i].pull_down_on = cfg[i].pull == pin_config_pkg::pull_down;
            pads[i].input_on     = cfg[i].input_on;
        end
        pads[0].data = pad_data[0];
        pads[1].data = pad_data[1];
        pads[2].data = clk_sel ? clk_pick : pad_data[2];
    end

endmodule : pin_config

// ---- hdl/pin_config_pkg.sv ----
// Constants, field layouts and carrier types for the configurable pin block.
package pin_config_pkg;

    // Register offsets on the serial configuration port.
    localparam logic [7:0] reset_offset       = 8'h01;
    localparam logic [7:0] pin0_config_offset = 8'h02;
    localparam logic [7:0] pin1_config_offset = 8'h03;
    localparam logic [7:0] pin2_config_offset = 8'h04;
    localparam logic [7:0] pin_input_offset   = 8'h05;
    localparam logic [7:0] pin_output_offset  = 8'h06;

    // Field positions and counts.
    localparam int software_reset_pos = 0;
    localparam int lane_count         = 5;
    localparam int pin_count          = 3;

    // Reset values.
    localparam logic [7:0] pin0_config_reset = 8'h05;
    localparam logic [7:0] pin1_config_reset = 8'h05;
    localparam logic [7:0] pin2_config_reset = 8'h04;
    localparam logic [2:0] software_output_reset = 3'h0;

    // Bus address of the configuration port, taken from the device id default.
    localparam logic [6:0] bus_address_default = 7'h57;

    // Pull field codes.
    localparam logic [1:0] pull_none = 2'h0;
    localparam logic [1:0] pull_down = 2'h1;
    localparam logic [1:0] pull_up   = 2'h2;

    // Pin 0 function codes.
    localparam logic [3:0] pin0_software    = 4'h0;
    localparam logic [3:0] pin0_clock_loss  = 4'h3;
    localparam logic [3:0] pin0_clock_found = 4'h4;
    localparam logic [3:0] pin0_power_reset = 4'h6;

    // Pin 1 function codes.
    localparam logic [3:0] pin1_power_reset = 4'h0;
    localparam logic [3:0] pin1_software    = 4'h1;
    localparam logic [3:0] pin1_pll_lock    = 4'h2;
    localparam logic [3:0] pin1_lane_first  = 4'h4;
    localparam logic [3:0] pin1_lane_last   = 4'h8;

    // Pin 2 function codes.
    localparam logic [3:0] pin2_software    = 4'h0;
    localparam logic [3:0] pin2_always_high = 4'h1;
    localparam logic [3:0] pin2_serial_clk  = 4'h2;
    localparam logic [3:0] pin2_parallel_clk = 4'h3;
    localparam logic [3:0] pin2_lane_clk    = 4'h4;

    // Serial port bit counter value once a byte is complete.
    localparam logic [3:0] bits_per_byte = 4'h8;

    typedef struct packed {
        logic [3:0] mode;
        logic [1:0] pull;
        logic       input_on;
        logic       driver_on;
    } pin_cfg_type;

    typedef struct packed {
        logic data;
        logic oe_n;
        logic pull_up_on;
        logic pull_down_on;
        logic input_on;
    } pin_pad_type;

    typedef struct packed {
        logic                 power_reset;
        logic                 pll_lock;
        logic                 input_clock_loss;
        logic                 input_clock_found;
        logic [lane_count-1:0] lane_data_loss;
    } status_type;

    typedef enum logic [3:0] {
        st_idle     = 4'h0,
        st_addr     = 4'h1,
        st_addr_ack = 4'h3,
        st_ptr      = 4'h2,
        st_ptr_ack  = 4'h6,
        st_wdata    = 4'h7,
        st_data_ack = 4'h5,
        st_rdata    = 4'h4,
        st_rack     = 4'hC
    } bus_state_type;

endpackage : pin_config_pkg

// ---- testbench/pin_config_sva.sv ----
// Port-level assertions for the configurable pin block.
`timescale 1ns/1ns
module pin_config_sva (
    input wire logic                              sys_clk,
    input wire logic                              rst,
    input wire logic                              scl_in,
    input wire pin_config_pkg::status_type        status_in,
    input wire pin_config_pkg::pin_pad_type [2:0] pads
);
    logic        untouched;
    logic        power_prev;
    logic [3:0]  power_stable;
    logic [3:0]  since_low;
    logic [11:0] ctl;
    assign ctl = {pads[2][3:0], pads[1][3:0], pads[0][3:0]};
    // Any bus traffic clears this, so idle checks only ever see reset values.
    always_ff @(posedge sys_clk) begin
        if (rst) untouched <= 1'b1;
        else if (!scl_in) untouched <= 1'b0;
    end
    always_ff @(posedge sys_clk) begin
        power_prev <= status_in.power_reset;
        if (rst || power_prev != status_in.power_reset) power_stable <= 4'h0;
        else if (power_stable != 4'hF) power_stable <= power_stable + 4'h1;
    end
    always_ff @(posedge sys_clk) begin
        if (rst || !scl_in) since_low <= 4'h0;
        else if (since_low != 4'hF) since_low <= since_low + 4'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_reset_done;
        $fell(rst);
    endsequence
    property p_reset_drivers;
        s_reset_done |-> !pads[0].oe_n && !pads[1].oe_n && pads[2].oe_n;
    endproperty
    property p_reset_pulls;
        s_reset_done |-> pads[0][2:1] == 2'h1 && pads[1][2:1] == 2'h1 && pads[2][2:1] == 2'h1;
    endproperty
    property p_reset_inputs;
        s_reset_done |-> !(pads[0].input_on || pads[1].input_on || pads[2].input_on);
    endproperty
    property p_pull_exclusive;
        pads[0][2:1] != 2'h3 && pads[1][2:1] != 2'h3 && pads[2][2:1] != 2'h3;
    endproperty
    property p_idle_data;
        untouched |-> !pads[0].data && !pads[2].data;
    endproperty
    property p_power_track;
        untouched && power_stable >= 4'h8 |-> pads[1].data == status_in.power_reset;
    endproperty
    property p_config_quiet;
        $changed(ctl) |-> since_low <= 4'h7;
    endproperty
    property p_idle_stable;
        untouched && !$past(rst) |-> $stable(ctl);
    endproperty
    a_reset_drivers: assert property (p_reset_drivers)
        else $error("driver enables wrong after reset");
    a_reset_pulls: assert property (p_reset_pulls)
        else $error("pull controls wrong after reset");
    a_reset_inputs: assert property (p_reset_inputs)
        else $error("input buffer on after reset");
    a_pull_exclusive: assert property (p_pull_exclusive)
        else $error("pull-up and pull-down both on");
    a_idle_data: assert property (p_idle_data)
        else $error("pin 0 or 2 not low in software mode");
    a_power_track: assert property (p_power_track)
        else $error("pin 1 does not follow power reset");
    a_config_quiet: assert property (p_config_quiet)
        else $error("pin controls changed without a bus write");
    a_idle_stable: assert property (p_idle_stable)
        else $error("pin controls moved while bus idle");
endmodule : pin_config_sva

// ---- testbench/board_pins.sv ----
// Board model of the three pins: an external source, resistors and floating lines.
`timescale 1ns/1ns
module board_pins (
    input  wire logic                              sys_clk,
    input  wire pin_config_pkg::pin_pad_type [2:0] pads,
    input  wire logic [2:0]                        ext_drive,
    input  wire logic [2:0]                        ext_level,
    output logic [2:0]                             pin_level
);
    logic [2:0] float_level = 3'h0;
    // A line nobody holds keeps no value, so it toggles to expose reads of a dead pin.
    always_ff @(posedge sys_clk) begin
        float_level <= ~pin_level;
    end
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (!pads[i].oe_n) pin_level[i] = pads[i].data;
            else if (ext_drive[i]) pin_level[i] = ext_level[i];
            else if (pads[i].pull_up_on) pin_level[i] = 1'b1;
            else if (pads[i].pull_down_on) pin_level[i] = 1'b0;
            else pin_level[i] = float_level[i];
        end
    end
endmodule : board_pins

// ---- testbench/tb_top.sv ----
// Bench for the pin block: serial-port register tests and pad checks.
`timescale 1ns/1ns
`define CHK(name, got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("Error %s expected %h seen %h", name, exp, got); \
        end \
    end
module tb_top;
    localparam logic [7:0] cfg0 = pin_config_pkg::pin0_config_offset;
    localparam pin_config_pkg::status_type stat_a = 9'h14A;
    logic                              sys_clk = 1'b0;
    logic                              rst = 1'b1;
    logic                              scl_in = 1'b1;
    logic                              sda_low = 1'b0;
    logic                              sda_in;
    logic                              sda_out;
    logic                              sda_oe_n;
    pin_config_pkg::status_type        status_in = 9'h000;
    logic [2:0]                        clks = 3'h0;
    logic [2:0]                        ext_drive = 3'h0;
    logic [2:0]                        ext_level = 3'h0;
    logic [2:0]                        pin_in;
    pin_config_pkg::pin_pad_type [2:0] pads;
    logic [7:0]                        rx;
    logic [7:0]                        rdata;
    logic                              ack_n;
    logic [2:0]                        sw;
    int                                n_fail = 0;
    int                                num_checks = 0;
    int                                cycles = 0;
    // The data line is open drain with a pull-up: either party may pull it low.
    assign sda_in = sda_oe_n ? ~sda_low : sda_out & ~sda_low;
    always #2 sys_clk = ~sys_clk;
    pin_config dut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .status_in(status_in),
        .serial_clock(clks[2]), .parallel_clock(clks[1]), .input_lane_clock(clks[0]),
        .pin_in(pin_in), .pads(pads));
    board_pins board (.sys_clk(sys_clk), .pads(pads), .ext_drive(ext_drive),
        .ext_level(ext_level), .pin_level(pin_in));
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    task automatic clock_bit(input logic b, output logic seen);
        sda_low <= ~b;
        tick(5);
        scl_in <= 1'b1;
        tick(4);
        seen = sda_in;
        tick(1);
        scl_in <= 1'b0;
        tick(3);
    endtask : clock_bit
    task automatic xfer_byte(input logic [7:0] tx, input logic last);
        for (int i = 7; i >= 0; i--) clock_bit(tx[i], rx[i]);
        clock_bit(last, ack_n);
    endtask : xfer_byte
    task automatic open_cycle(input logic rd);
        sda_low <= 1'b0;
        tick(3);
        scl_in <= 1'b1;
        tick(5);
        sda_low <= 1'b1;
        tick(5);
        scl_in <= 1'b0;
        tick(3);
        xfer_byte({pin_config_pkg::bus_address_default, rd}, 1'b1);
        `CHK("address ack", ack_n, 1'b0)
    endtask : open_cycle
    task automatic bus_stop();
        sda_low <= 1'b1;
        tick(5);
        scl_in <= 1'b1;
        tick(5);
        sda_low <= 1'b0;
        tick(5);
    endtask : bus_stop
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        open_cycle(1'b0);
        xfer_byte(a, 1'b1);
        xfer_byte(d, 1'b1);
        bus_stop();
    endtask : reg_write
    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        open_cycle(1'b0);
        xfer_byte(a, 1'b1);
        open_cycle(1'b1);
        xfer_byte(8'hFF, 1'b1);
        rdata = rx;
        bus_stop();
        `CHK("register", rdata, exp)
    endtask : check_reg
    function automatic logic exp_data(input int p, input logic [3:0] m,
                                      input pin_config_pkg::status_type s);
        exp_data = 1'b0;
        if (p == 0) begin
            case (m)
                4'h0: exp_data = sw[0];
                4'h3: exp_data = s.input_clock_loss;
                4'h4: exp_data = s.input_clock_found;
                4'h6: exp_data = s.power_reset;
                default: exp_data = 1'b0;
            endcase
        end else if (p == 1) begin
            case (m)
                4'h0: exp_data = s.power_reset;
                4'h1: exp_data = sw[1];
                4'h2: exp_data = s.pll_lock;
                4'h4, 4'h5, 4'h6, 4'h7, 4'h8: exp_data = s.lane_data_loss[m - 4'h4];
                default: exp_data = 1'b0;
            endcase
        end else begin
            case (m)
                4'h0: exp_data = sw[2];
                4'h1: exp_data = 1'b1;
                4'h2: exp_data = clks[2];
                4'h3: exp_data = clks[1];
                4'h4: exp_data = clks[0];
                default: exp_data = 1'b0;
            endcase
        end
    endfunction : exp_data
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        tick(6);
        rst <= 1'b0;
        tick(4);
        status_in.power_reset <= 1'b1;
        tick(12);
        `CHK("pin1 data", pads[1].data, 1'b1)
        `CHK("driver enables", {pads[2].oe_n, pads[1].oe_n, pads[0].oe_n}, 3'h4)
        check_reg(cfg0, 8'h05);
        check_reg(8'h03, 8'h05);
        check_reg(8'h04, 8'h04);
        check_reg(8'h06, 8'h00);
        $display("test reset values done");
        for (int v = 0; v < 4; v++) begin
            reg_write(cfg0, {4'h0, v[1:0], v[0], v[1]});
            `CHK("pad controls", pads[0][3:0], {~v[1], v == 2, v == 1, v[0]})
            check_reg(cfg0, {4'h0, v[1:0], v[0], v[1]});
        end
        $display("test pad controls done");
        for (int k = 0; k < 2; k++) begin
            status_in <= k ? ~stat_a : stat_a;
            clks <= k ? 3'h2 : 3'h5;
            sw = k ? 3'h2 : 3'h5;
            reg_write(8'h06, {5'h00, sw});
            for (int p = 0; p < 3; p++) begin
                for (int m = 0; m < 16; m++) begin
                    reg_write(cfg0 + p[7:0], {m[3:0], 4'h5});
                    `CHK("pad data", pads[p].data, exp_data(p, m[3:0], status_in))
                end
            end
        end
        $display("test pin functions done");
        reg_write(cfg0, 8'h02);
        reg_write(8'h04, 8'h00);
        ext_drive <= 3'h5;
        ext_level <= 3'h5;
        check_reg(8'h05, 8'h01);
        ext_level <= 3'h4;
        check_reg(8'h05, 8'h00);
        ext_drive <= 3'h0;
        $display("test pin inputs done");
        reg_write(cfg0, 8'hA6);
        reg_write(8'h04, 8'h01);
        reg_write(8'h01, 8'h01);
        check_reg(8'h01, 8'h00);
        check_reg(cfg0, 8'h05);
        check_reg(8'h06, 8'h00);
        `CHK("pin2 driver", pads[2].oe_n, 1'b1)
        reg_write(8'h20, 8'hFF);
        check_reg(8'h20, 8'h00);
        $display("test soft reset and unmapped done");
        complete_run();
    end
endmodule : tb_top
bind pin_config pin_config_sva u_sva (.sys_clk(sys_clk), .rst(rst), .scl_in(scl_in),
    .status_in(status_in), .pads(pads));
